// >>> rtl/rps_pkg.sv
// package for the reset and pin-state controller
// assumes a single reference clock domain; no software-visible registers
package rps_pkg;
  // power-on reset stretch, in reference clock cycles
  localparam int unsigned POR_CYCLES      = 16;
  localparam int unsigned POR_CNT_W       = 5;
  // host must wait this many reference clocks before its first serial command
  localparam int unsigned HOST_WAIT_CYC   = 100;
  localparam int unsigned WAIT_CNT_W      = 7;
  // soft reset pulse length, in reference clock cycles
  localparam int unsigned SOFT_RST_CYCLES = 8;
  localparam int unsigned SOFT_CNT_W      = 4;
  // boot strap value meaning auto-configure
  localparam logic        BOOT_AUTO       = 1'b1;

  // sequencer states, one-hot
  typedef enum logic [4:0] {
    RPS_ST_POR     = 5'h01,
    RPS_ST_RESET   = 5'h02,
    RPS_ST_STRAP   = 5'h04,
    RPS_ST_RUN     = 5'h08,
    RPS_ST_STANDBY = 5'h10
  } rps_state_t;
endpackage : rps_pkg

// >>> rtl/rps_reset_ctrl.sv
// reset sources and pin-state control: power-on, hard pin and soft reset
// assumes i_sys_clk is the reference clock and i_srst is the power-on indication
// Notes on behaviour
// - internal reset generated automatically at power-up
// - hard reset pin low resets, release restarts
// - host soft reset over serial bus accepted in run only, ignored in standby
// - serial data line never driven high
// - boot data input pull-up always enabled
// - outputs high impedance while hard reset held
// - soft reset starts on control register write in run; ignored in standby
// - boot input sampled after reset selects config when no boot memory is fitted; fitted forces host config
// - standby input high requests hard standby
`timescale 1ns/10ps
`default_nettype none
module rps_reset_ctrl
  import rps_pkg::*;
(
  input  wire logic i_sys_clk,          // reference clock, 25 MHz
  input  wire logic i_srst,             // power-on reset, sync, active high
  input  wire logic i_hard_reset_n,     // external hard reset pin, active low
  input  wire logic i_standby,          // standby pin, high requests hard standby
  input  wire logic i_boot_memory_data_in, // boot memory data pin
  input  wire logic i_boot_mem_fitted,  // boot memory present, same-domain strap
  input  wire logic i_soft_reset_wr,    // one-cycle decoded write of soft reset control
  input  wire logic i_sda_pull_low,     // serial engine wants data line low
  output logic      o_host_serial_data_line_out, // data line drive value, always 0
  output logic      o_host_serial_data_line_oe,  // high while pulling line low
  output logic      o_boot_pullup_en,   // boot input pull-up enable
  output logic      o_core_reset,       // reset to the rest of the device
  output logic      o_outputs_hiz,      // all device outputs to high impedance
  output logic      o_standby,          // hard standby active
  output logic      o_auto_config,      // strap result: 1 auto-config, 0 host config
  output logic      o_host_ready        // serial commands may be accepted
);
  import rps_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state record
  typedef struct packed {
    logic                  rst_m;   // synchroniser stage 1, reset pin
    logic                  rst_s;   // synchroniser stage 2, reset pin
    logic                  stb_m;   // synchroniser stage 1, standby
    logic                  stb_s;   // synchroniser stage 2, standby
    logic                  boot_m;  // synchroniser stage 1, boot input
    logic                  boot_s;  // synchroniser stage 2, boot input
    rps_state_t            st;      // sequencer state
    logic [POR_CNT_W-1:0]  por_cnt; // power-on stretch count
    logic [SOFT_CNT_W-1:0] soft_cnt;// soft reset count
    logic [WAIT_CNT_W-1:0] wait_cnt;// cycles since restart
    logic                  sda_oe;  // data line pull-down
    logic                  core_rst;
    logic                  hiz;
    logic                  stby;
    logic                  auto_cfg;
    logic                  ready;
  } rps_reg_t;

  rps_reg_t s_r;   // registered state
  rps_reg_t s_nxt; // next state

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    s_nxt        = s_r;
    // pin inputs pass two flops before any use
    s_nxt.rst_m  = i_hard_reset_n;
    s_nxt.rst_s  = s_r.rst_m;
    s_nxt.stb_m  = i_standby;
    s_nxt.stb_s  = s_r.stb_m;
    s_nxt.boot_m = i_boot_memory_data_in;
    s_nxt.boot_s = s_r.boot_m;
    if (s_r.wait_cnt != WAIT_CNT_W'(HOST_WAIT_CYC))
    begin
      s_nxt.wait_cnt = s_r.wait_cnt + WAIT_CNT_W'(1);
    end
    case (s_r.st)
      RPS_ST_POR:
      begin
        // stretch power-on reset without any external pulse
        s_nxt.core_rst = 1'b1;
        s_nxt.hiz      = 1'b1;
        s_nxt.por_cnt  = s_r.por_cnt + POR_CNT_W'(1);
        if (s_r.por_cnt == POR_CNT_W'(POR_CYCLES - 1))
        begin
          s_nxt.st = RPS_ST_RESET;
        end
      end
      RPS_ST_RESET:
      begin
        // held while pin low or soft count runs
        s_nxt.core_rst = 1'b1;
        s_nxt.hiz      = !s_r.rst_s;
        s_nxt.wait_cnt = '0;
        s_nxt.ready    = 1'b0;
        if (s_r.soft_cnt != '0)
        begin
          s_nxt.soft_cnt = s_r.soft_cnt - SOFT_CNT_W'(1);
        end
        else if (s_r.rst_s)
        begin
          s_nxt.st = RPS_ST_STRAP;
        end
      end
      RPS_ST_STRAP:
      begin
        // sample boot input once after reset
        s_nxt.core_rst = 1'b0;
        s_nxt.hiz      = 1'b0;
        s_nxt.auto_cfg = !i_boot_mem_fitted && (s_r.boot_s == BOOT_AUTO);
        s_nxt.st       = RPS_ST_RUN;
      end
      RPS_ST_RUN, RPS_ST_STANDBY:
      begin
        // standby follows the pin level
        s_nxt.stby  = s_r.stb_s;
        s_nxt.st    = s_r.stb_s ? RPS_ST_STANDBY : RPS_ST_RUN;
        // host gate opens after the mandated wait
        s_nxt.ready = (s_r.wait_cnt == WAIT_CNT_W'(HOST_WAIT_CYC));
        if (i_soft_reset_wr && (s_r.st == RPS_ST_RUN))
        begin
          // soft reset starts on the control write
          s_nxt.soft_cnt = SOFT_CNT_W'(SOFT_RST_CYCLES);
          s_nxt.core_rst = 1'b1;
          s_nxt.ready    = 1'b0;
          s_nxt.stby     = 1'b0;
          s_nxt.st       = RPS_ST_RESET;
        end
      end
      default:
      begin
        s_nxt.st = RPS_ST_POR;
      end
    endcase
    // hard reset pin overrides everything but power-on
    if (!s_r.rst_s && (s_r.st != RPS_ST_POR))
    begin
      s_nxt.st       = RPS_ST_RESET;
      s_nxt.core_rst = 1'b1;
      s_nxt.hiz      = 1'b1;
      s_nxt.stby     = 1'b0;
      s_nxt.ready    = 1'b0;
      s_nxt.sda_oe   = 1'b0;
    end
    // only ever pulls low, and only while the next state is run; keying on the
    // next state keeps the pull from outliving run by one cycle
    s_nxt.sda_oe = (s_nxt.st == RPS_ST_RUN) && i_sda_pull_low;
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register; power-on reset loads constants only
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      s_r          <= '0;
      s_r.st       <= RPS_ST_POR;
      s_r.core_rst <= 1'b1;
      s_r.hiz      <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops; data line value and boot pull-up enable tied constant
  assign o_host_serial_data_line_out = 1'b0;
  assign o_host_serial_data_line_oe  = s_r.sda_oe;
  assign o_boot_pullup_en = 1'b1;
  assign o_core_reset     = s_r.core_rst;
  assign o_outputs_hiz    = s_r.hiz;
  assign o_standby        = s_r.stby;
  assign o_auto_config    = s_r.auto_cfg;
  assign o_host_ready     = s_r.ready;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  AST_SDA_LOW_ONLY: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    s_r.sda_oe |-> (s_r.st == RPS_ST_RUN))
    else $error("data line driven outside run");
  AST_POR_RESET: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (s_r.st == RPS_ST_POR) |-> o_core_reset)
    else $error("core reset low during power-on");
  AST_HARD_HIZ: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (!s_r.rst_s && s_r.st != RPS_ST_POR) |=> o_outputs_hiz && o_core_reset)
    else $error("outputs not hiz in hard reset");
  AST_HARD_RELEASE: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (s_r.st == RPS_ST_RESET && s_r.rst_s && s_r.soft_cnt == '0) |=> ##1 !o_core_reset)
    else $error("no restart after reset release");
  AST_SOFT_START: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (i_soft_reset_wr && s_r.st == RPS_ST_RUN && s_r.rst_s) |=> o_core_reset [*8])
    else $error("soft reset too short");
  AST_STANDBY: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (s_r.st == RPS_ST_RUN && s_r.stb_s && s_r.rst_s && !i_soft_reset_wr) |=> o_standby)
    else $error("standby not entered");
  // a control write that lands in standby must leave the core running
  AST_STBY_REFUSE: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (s_r.st == RPS_ST_STANDBY && s_r.stb_s && s_r.rst_s) |=> !o_core_reset)
    else $error("core reset raised in standby");
  // outputs are released before run is reached
  AST_HIZ_RUN: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (s_r.st == RPS_ST_RUN) |-> !o_outputs_hiz)
    else $error("outputs hiz while running");
  AST_READY_WAIT: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    o_host_ready |-> (s_r.wait_cnt == WAIT_CNT_W'(HOST_WAIT_CYC)))
    else $error("host ready before wait");
  AST_STRAP: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (s_r.st == RPS_ST_STRAP && !i_boot_mem_fitted) |=> (o_auto_config == $past(s_r.boot_s)))
    else $error("strap sampled wrong");
  AST_PULLUP: assert property (@(posedge i_sys_clk) o_boot_pullup_en)
    else $error("pull-up disabled");
  COV_SOFT: cover property (@(posedge i_sys_clk) disable iff (i_srst)
    i_soft_reset_wr && s_r.st == RPS_ST_RUN);
  COV_HARD: cover property (@(posedge i_sys_clk) disable iff (i_srst)
    s_r.st == RPS_ST_RUN ##1 !s_r.rst_s);
  COV_STBY: cover property (@(posedge i_sys_clk) disable iff (i_srst)
    s_r.st == RPS_ST_STANDBY);
  COV_READY: cover property (@(posedge i_sys_clk) disable iff (i_srst) $rose(o_host_ready));
endmodule : rps_reset_ctrl
`default_nettype wire

// >>> tb/rps_host_model.sv
// host model: soft reset writes and data line pulls
// assumes the bench says when to act; shares the reference clock
`timescale 1ns/10ps
`default_nettype none
module rps_host_model
  import rps_pkg::*;
(
  input  wire logic       i_sys_clk,              // reference clock
  input  wire logic       i_srst,                 // sync reset
  input  wire logic       i_host_ready,           // device takes commands
  input  wire logic [1:0] i_req,                  // 1 polite write, 2 blind
  input  wire logic       i_pull,                 // want data line low
  output logic            o_soft_reset_wr = 1'b0, // valid from time zero
  output logic            o_sda_pull_low  = 1'b0  // data line low request
);
  // host waits for ready; blind mode exists only to probe refusals
  always @(posedge i_sys_clk)
  begin
    o_soft_reset_wr <= !i_srst && ((i_req == 2'h1 && i_host_ready) || i_req == 2'h2);
    o_sda_pull_low  <= !i_srst && i_pull && i_host_ready;
  end
endmodule : rps_host_model
`default_nettype wire

// >>> tb/tb.sv
// bench for the reset and pin-state controller
// assumes the package and host model compile first
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
  import rps_pkg::*;
  // clock never stops, so standby and reset need no clock gating
  logic       clk = 1'b0, srst = 1'b1, rst_n = 1'b1, stby = 1'b0, boot = 1'b1, fit = 1'b0;
  logic [1:0] req = 2'h0;
  logic       pl = 1'b0;
  logic       wr, pull, oe, dout, pup, core, hiz, sby, auto, rdy;
  wire        line = oe ? dout : 1'b1; // board pull-up
  int         n_mismatch = 0, checks = 0, cyc = 0, n;
  always #20 clk = ~clk;
  rps_reset_ctrl u_rps_reset_ctrl (.i_sys_clk(clk), .i_srst(srst), .i_hard_reset_n(rst_n),
    .i_standby(stby), .i_boot_memory_data_in(boot), .i_boot_mem_fitted(fit),
    .i_soft_reset_wr(wr), .i_sda_pull_low(pull), .o_host_serial_data_line_out(dout),
    .o_host_serial_data_line_oe(oe), .o_boot_pullup_en(pup), .o_core_reset(core),
    .o_outputs_hiz(hiz), .o_standby(sby), .o_auto_config(auto), .o_host_ready(rdy));
  rps_host_model u_rps_host_model (.i_sys_clk(clk), .i_srst(srst), .i_host_ready(rdy),
    .i_req(req), .i_pull(pl), .o_soft_reset_wr(wr), .o_sda_pull_low(pull));
  ////////////////////////////////////////////////////////////////////////////////
  // pins that must hold in every state, checked off the sampling edge
  always @(negedge clk)
  begin
    if (oe === 1'b1) `CHK("sda_out", 1'b0, dout)
    `CHK("pullup", 1'b1, pup)
  end
  // hang guard: tests need well under a thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic wait_core(input logic v);
    n = 0;
    while (core !== v && n < 200)
    begin
      tick(1);
      n++;
    end
  endtask : wait_core
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_por;
    wait_core(1'b0);
    `CHK("por_len", 1'b1, n >= POR_CYCLES)
    `CHK("hiz", 1'b0, hiz)
    `CHK("auto", BOOT_AUTO, auto)
    n = 0;
    while (rdy !== 1'b1 && n < 300)
    begin
      tick(1);
      n++;
    end
    `CHK("ready_wait", 1'b1, n >= HOST_WAIT_CYC - 2)
    $display("test por done");
  endtask : t_por
  task automatic t_sda;
    @(posedge clk) pl <= 1'b1;
    tick(3);
    `CHK("line_low", 1'b0, line)
    @(posedge clk) pl <= 1'b0;
    tick(3);
    `CHK("line_free", 1'b0, oe)
    $display("test sda done");
  endtask : t_sda
  task automatic t_soft;
    @(posedge clk) req <= 2'h1;
    fit <= 1'b1;
    @(posedge clk) req <= 2'h0;
    tick(1);
    `CHK("soft_core", 1'b1, core)
    `CHK("soft_rdy", 1'b0, rdy)
    wait_core(1'b0);
    `CHK("soft_len", 1'b1, n >= SOFT_RST_CYCLES)
    `CHK("fit_auto", 1'b0, auto)
    @(posedge clk) fit <= 1'b0;
    $display("test soft done");
  endtask : t_soft
  task automatic t_hard;
    @(posedge clk) rst_n <= 1'b0;
    boot <= 1'b0;
    tick(50);
    `CHK("hard_core", 1'b1, core)
    `CHK("hard_hiz", 1'b1, hiz)
    `CHK("hard_oe", 1'b0, oe)
    @(posedge clk) rst_n <= 1'b1;
    wait_core(1'b0);
    `CHK("restart", 1'b0, core)
    `CHK("host_cfg", 1'b0, auto)
    @(posedge clk) boot <= 1'b1;
    $display("test hard done");
  endtask : t_hard
  task automatic t_stby;
    // host keeps its post-reset wait before any further command
    n = 0;
    while (rdy !== 1'b1 && n < 300)
    begin
      tick(1);
      n++;
    end
    `CHK("rdy_wait_hard", 1'b1, n >= HOST_WAIT_CYC - 2)
    @(posedge clk) stby <= 1'b1;
    tick(4);
    `CHK("stby_on", 1'b1, sby)
    @(posedge clk) req <= 2'h2;
    @(posedge clk) req <= 2'h0;
    tick(3);
    `CHK("stby_refuse", 1'b0, core)
    @(posedge clk) stby <= 1'b0;
    tick(4);
    `CHK("stby_off", 1'b0, sby)
    $display("test stby done");
  endtask : t_stby
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_por();
    t_sda();
    t_soft();
    t_hard();
    t_stby();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
